// ==== rtl/sps_pair_buf.sv ====
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sps_pair_buf #(
  parameter int W = sps_pkg::WORD_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Filling side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  logic [W-1:0] d0_r, d0_nxt, d1_r, d1_nxt;
  logic v0_r, v0_nxt, v1_r, v1_nxt;
  logic push, pop;

  assign in_ready = !v1_r;
  assign out_valid = v0_r;
  assign out_data = d0_r;

  always_comb
  begin
    push = in_valid && !v1_r;
    pop = v0_r && out_ready;
    d0_nxt = d0_r;
    d1_nxt = d1_r;
    v0_nxt = v0_r;
    v1_nxt = v1_r;
    case ({push, pop})
      2'b10:
      begin
        if (!v0_r)
        begin
          d0_nxt = in_data;
          v0_nxt = 1'b1;
        end
        else
        begin
          d1_nxt = in_data;
          v1_nxt = 1'b1;
        end
      end
      2'b01:
      begin
        d0_nxt = d1_r;
        v0_nxt = v1_r;
        v1_nxt = 1'b0;
      end
      2'b11:
      begin
        d0_nxt = in_data;
        v0_nxt = 1'b1;
      end
      default:
      begin
        v0_nxt = v0_r;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      d0_r <= '0;
      d1_r <= '0;
      v0_r <= 1'b0;
      v1_r <= 1'b0;
    end
    else
    begin
      d0_r <= d0_nxt;
      d1_r <= d1_nxt;
      v0_r <= v0_nxt;
      v1_r <= v1_nxt;
    end
  end

endmodule : sps_pair_buf
`default_nettype wire

// ==== rtl/sps_pin_select.sv ====
// Shared-pin function select, frame format detection and stream sampling
`timescale 1ns/1ps
`default_nettype none
// How it works
// (RQ1) Transfer acknowledge pin driven low when a host transfer completes, released otherwise.
// (RQ2) Streams carry 32, 64 or 128 channels at 2.048, 4.096, 8.192 Mb/s.
// (RQ3) Non-multiplexed bus at 8.192 or 4.096 rate: input-6 pin is address bit 6.
// (RQ4) At 2.048, 4.096 eight-by-four, or multiplexed bus: input-6 pin is stream 6.
// (RQ5) Non-multiplexed bus at 8.192 rate: input-7 pin is address bit 7.
// (RQ6) At 2.048, 4.096 eight-by-four, or multiplexed bus: input-7 pin is stream 7.
// (RQ7) Frame pulse accepted in either framing format, format found automatically.
// (RQ8) Outside party supplies a 4.096 or 8.192 MHz serial clock matching the mode.
// (RQ9) Non-multiplexed bus: three low shared pins are address bits 0 to 2.
// (RQ10) Sixteen-by-eight configuration: three low shared pins are streams 8 to 10.
// (RQ11) Non-multiplexed bus: next three shared pins are address bits 3 to 5.
// (RQ12) Sixteen-by-eight configuration: upper three shared pins are streams 11 to 13.
// (RQ13) Board ties address 6 or 7 to the output-6 or output-7 pin when both needed.
// (RQ14) Host holds chip select low to enable a read or write.
// (RQ15) Pin functions derive directly from the current configuration settings.
module sps_pin_select (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Host bus pins
  input wire logic host_cs_n,
  input wire logic host_ds,
  output logic transfer_ack_n_o,
  output logic transfer_ack_n_oe,
  output logic [7:0] host_addr,
  output logic host_addr_valid,
  // Serial pins
  input wire logic [5:0] serial_in_0_to_5,
  input wire logic shared_in6_addr6_pin,
  input wire logic shared_in7_addr7_pin,
  input wire logic [2:0] low_addr_or_serial_8_10,
  input wire logic [2:0] mid_addr_or_serial_11_13,
  input wire logic shared_out6_addr6_pin,
  input wire logic shared_out7_addr7_pin,
  input wire logic frame_sync_in,
  input wire logic serial_clk,
  // Sampled stream word
  output logic [13:0] st_word,
  output logic st_valid,
  input wire logic st_ready,
  // Pin function state
  output logic [5:0] pin_func,
  output logic frame_fmt_gci
);

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  logic [19:0] s1_r, s2_r;
  logic sclk_d_r, fr_d_r;
  logic fr_s, sclk_s, cs_n_s, ds_s, out7_s, out6_s, in7_s, in6_s;
  logic [2:0] mid_s, low_s;
  logic [5:0] ser_s;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      sclk_d_r <= 1'b0;
      fr_d_r <= 1'b0;
    end
    else
    begin
      s1_r <= {frame_sync_in, serial_clk, host_cs_n, host_ds, shared_out7_addr7_pin,
               shared_out6_addr6_pin, mid_addr_or_serial_11_13, low_addr_or_serial_8_10,
               shared_in7_addr7_pin, shared_in6_addr6_pin, serial_in_0_to_5};
      s2_r <= s1_r;
      sclk_d_r <= s2_r[18];
      fr_d_r <= s2_r[19];
    end
  end

  assign {fr_s, sclk_s, cs_n_s, ds_s, out7_s, out6_s, mid_s, low_s, in7_s, in6_s, ser_s} = s2_r;

  // ----------------------------------------------------------------
  // Mode configuration and pin function
  // ----------------------------------------------------------------
  logic [7:0] mode_r, mode_nxt;
  logic [1:0] rate;
  logic clk8, mux_bus, cfg8x4, cfg16x8;
  logic [5:0] func_c;
  logic [5:0] func_r;
  logic [7:0] chan_r, chan_nxt;

  assign rate = mode_r[sps_pkg::MODE_RATE_LSB +: 2];
  assign clk8 = mode_r[sps_pkg::MODE_CLK8_BIT];
  assign mux_bus = mode_r[sps_pkg::MODE_MUX_BIT];
  assign cfg8x4 = mode_r[sps_pkg::MODE_8X4_BIT];
  assign cfg16x8 = mode_r[sps_pkg::MODE_16X8_BIT];

  always_comb
  begin
    mode_nxt = mode_r;
    if (reg_wr && reg_addr == sps_pkg::REG_MODE)
      mode_nxt = reg_wdata;
    // Pin functions are decoded from the live mode and registered into func_r one cycle later [RQ15]
    func_c = '0;
    func_c[sps_pkg::FUNC_IN6_ADDR] = !mux_bus && (rate == sps_pkg::RATE_8M ||
                                     (rate == sps_pkg::RATE_4M && !cfg8x4)); // [RQ3] [RQ4]
    func_c[sps_pkg::FUNC_IN7_ADDR] = !mux_bus && rate == sps_pkg::RATE_8M; // [RQ5] [RQ6]
    func_c[sps_pkg::FUNC_LOW_ADDR] = !mux_bus; // [RQ9]
    func_c[sps_pkg::FUNC_MID_ADDR] = !mux_bus; // [RQ11]
    func_c[sps_pkg::FUNC_LOW_SER] = mux_bus && cfg16x8; // [RQ10]
    func_c[sps_pkg::FUNC_MID_SER] = mux_bus && cfg16x8; // [RQ12]
    chan_nxt = (rate == sps_pkg::RATE_4M || rate == sps_pkg::RATE_8M) ?
               sps_pkg::CHAN_BASE << rate : sps_pkg::CHAN_BASE; // [RQ2]
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      mode_r <= sps_pkg::MODE_RST;
      func_r <= '0;
      chan_r <= sps_pkg::CHAN_BASE;
    end
    else
    begin
      mode_r <= mode_nxt;
      func_r <= func_c;
      chan_r <= chan_nxt;
    end
  end

  assign pin_func = func_r;

  a_in6_addr_func: assert property (@(posedge clk_sys) disable iff (srst)
    !mux_bus && rate == sps_pkg::RATE_8M ##1 !srst |-> pin_func[sps_pkg::FUNC_IN6_ADDR]) // [RQ3]
    else $error("input-6 pin not address at 8.192 rate");
  a_in6_ser_func: assert property (@(posedge clk_sys) disable iff (srst)
    (mux_bus || rate == sps_pkg::RATE_2M || (rate == sps_pkg::RATE_4M && cfg8x4))
    |=> !pin_func[sps_pkg::FUNC_IN6_ADDR]) // [RQ4]
    else $error("input-6 pin not serial");
  a_in7_addr_func: assert property (@(posedge clk_sys) disable iff (srst)
    $past(!mux_bus && rate == sps_pkg::RATE_8M) == pin_func[sps_pkg::FUNC_IN7_ADDR]) // [RQ5]
    else $error("input-7 pin function wrong");
  a_in7_ser_func: assert property (@(posedge clk_sys) disable iff (srst)
    (rate == sps_pkg::RATE_4M && cfg8x4) |=> !pin_func[sps_pkg::FUNC_IN7_ADDR]) // [RQ6]
    else $error("input-7 pin not serial in eight-by-four");
  a_chan_count: assert property (@(posedge clk_sys) disable iff (srst)
    rate == sps_pkg::RATE_8M ##1 rate == sps_pkg::RATE_8M |-> chan_r == 8'h80) // [RQ2]
    else $error("channel count not 128 at 8.192 rate");

  // ----------------------------------------------------------------
  // Frame format detection
  // ----------------------------------------------------------------
  logic [15:0] len_cnt_r, len_cnt_nxt, len_hi_r, len_hi_nxt, len_lo_r, len_lo_nxt;
  logic fr_edge, fmt_valid, fmt_gci_r, fmt_gci_nxt;

  always_comb
  begin
    fr_edge = fr_s != fr_d_r;
    len_hi_nxt = len_hi_r;
    len_lo_nxt = len_lo_r;
    len_cnt_nxt = (len_cnt_r == sps_pkg::LEN_MAX) ? len_cnt_r : len_cnt_r + 16'h0001;
    if (fr_edge)
    begin
      len_cnt_nxt = 16'h0001;
      if (fr_d_r)
        len_hi_nxt = len_cnt_r;
      else
        len_lo_nxt = len_cnt_r;
    end
    // A short high phase is an active-high pulse, otherwise active-low [RQ7]
    fmt_valid = len_hi_r != 16'h0000 && len_lo_r != 16'h0000;
    fmt_gci_nxt = fmt_valid ? (len_hi_r < len_lo_r) : fmt_gci_r;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      len_cnt_r <= '0;
      len_hi_r <= '0;
      len_lo_r <= '0;
      fmt_gci_r <= 1'b0;
    end
    else
    begin
      len_cnt_r <= len_cnt_nxt;
      len_hi_r <= len_hi_nxt;
      len_lo_r <= len_lo_nxt;
      fmt_gci_r <= fmt_gci_nxt;
    end
  end

  assign frame_fmt_gci = fmt_gci_r;

  a_fmt_detect: assert property (@(posedge clk_sys) disable iff (srst)
    fmt_valid && $stable(len_hi_r) && $stable(len_lo_r)
    |=> frame_fmt_gci == $past(len_hi_r < len_lo_r)) // [RQ7]
    else $error("frame format not taken from pulse phases");

  // ----------------------------------------------------------------
  // Bit sampling on the serial clock
  // ----------------------------------------------------------------
  logic [1:0] bit_cnt_r, bit_cnt_nxt, bit_mask;
  logic sclk_rise, frame_start, sample_en, ovr_r, ovr_nxt, buf_in_ready;
  logic [13:0] word_c;

  always_comb
  begin
    // Serial clock to bit rate ratio; the clock pin follows the mode [RQ8]
    case ({clk8, rate})
      3'b000, 3'b011: bit_mask = 2'h1;
      3'b100, 3'b111: bit_mask = 2'h3;
      3'b101: bit_mask = 2'h1;
      default: bit_mask = 2'h0;
    endcase
    sclk_rise = sclk_s && !sclk_d_r;
    frame_start = fr_edge && (fr_s == fmt_gci_r);
    bit_cnt_nxt = bit_cnt_r;
    if (frame_start)
      bit_cnt_nxt = 2'h0;
    else if (sclk_rise)
      bit_cnt_nxt = bit_cnt_r + 2'h1;
    sample_en = sclk_rise && ((bit_cnt_r & bit_mask) == 2'h0);
    word_c[5:0] = ser_s;
    word_c[6] = in6_s && !func_r[sps_pkg::FUNC_IN6_ADDR]; // [RQ4]
    word_c[7] = in7_s && !func_r[sps_pkg::FUNC_IN7_ADDR]; // [RQ6]
    word_c[10:8] = low_s & {3{func_r[sps_pkg::FUNC_LOW_SER]}}; // [RQ10]
    word_c[13:11] = mid_s & {3{func_r[sps_pkg::FUNC_MID_SER]}}; // [RQ12]
    ovr_nxt = ovr_r;
    if (reg_wr && reg_addr == sps_pkg::REG_STAT && reg_wdata[sps_pkg::STAT_OVR_BIT])
      ovr_nxt = 1'b0;
    if (sample_en && !buf_in_ready)
      ovr_nxt = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      bit_cnt_r <= '0;
      ovr_r <= 1'b0;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_nxt;
      ovr_r <= ovr_nxt;
    end
  end

  sps_pair_buf #(.W(sps_pkg::WORD_W)) u_buf (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_data(word_c),
    .in_valid(sample_en),
    .in_ready(buf_in_ready),
    .out_data(st_word),
    .out_valid(st_valid),
    .out_ready(st_ready)
  );

  a_low_ser_mask: assert property (@(posedge clk_sys) disable iff (srst)
    sample_en && buf_in_ready && !st_valid && !func_r[sps_pkg::FUNC_LOW_SER]
    |=> st_valid && st_word[10:8] == 3'h0) // [RQ10]
    else $error("low pins sampled while not streams");

  // ----------------------------------------------------------------
  // Host address and transfer acknowledge
  // ----------------------------------------------------------------
  sps_pkg::sps_ack_t ack_st_r, ack_st_nxt;
  logic [1:0] ack_cnt_r, ack_cnt_nxt;
  logic [7:0] haddr_r, haddr_nxt;
  logic hval_r, hval_nxt, ack_oe_r, ack_n_r, access;

  always_comb
  begin
    access = !cs_n_s && ds_s;
    ack_st_nxt = ack_st_r;
    ack_cnt_nxt = ack_cnt_r;
    haddr_nxt = haddr_r;
    hval_nxt = hval_r;
    case (ack_st_r)
      sps_pkg::ACK_IDLE:
      begin
        if (access)
        begin
          ack_st_nxt = sps_pkg::ACK_WAIT;
          ack_cnt_nxt = sps_pkg::ACK_DLY_CYC - 2'h1;
          hval_nxt = !mux_bus;
          haddr_nxt[2:0] = func_r[sps_pkg::FUNC_LOW_ADDR] ? low_s : 3'h0; // [RQ9]
          haddr_nxt[5:3] = func_r[sps_pkg::FUNC_MID_ADDR] ? mid_s : 3'h0; // [RQ11]
          // Address 6 and 7 come from the output pins when inputs carry streams on a non-multiplexed bus [RQ13]
          haddr_nxt[6] = func_r[sps_pkg::FUNC_IN6_ADDR] ? in6_s : (!mux_bus && out6_s); // [RQ3]
          haddr_nxt[7] = func_r[sps_pkg::FUNC_IN7_ADDR] ? in7_s : (!mux_bus && out7_s); // [RQ5]
        end
      end
      sps_pkg::ACK_WAIT:
      begin
        if (!access)
          ack_st_nxt = sps_pkg::ACK_IDLE;
        else if (ack_cnt_r == 2'h0)
          ack_st_nxt = sps_pkg::ACK_DRIVE; // [RQ1]
        else
          ack_cnt_nxt = ack_cnt_r - 2'h1;
      end
      sps_pkg::ACK_DRIVE:
      begin
        if (!access)
          ack_st_nxt = sps_pkg::ACK_IDLE; // [RQ1]
      end
      default:
      begin
        ack_st_nxt = sps_pkg::ACK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ack_st_r <= sps_pkg::ACK_IDLE;
      ack_cnt_r <= '0;
      haddr_r <= '0;
      hval_r <= 1'b0;
      ack_oe_r <= 1'b0;
      ack_n_r <= 1'b1;
    end
    else
    begin
      ack_st_r <= ack_st_nxt;
      ack_cnt_r <= ack_cnt_nxt;
      haddr_r <= haddr_nxt;
      hval_r <= hval_nxt;
      ack_oe_r <= ack_st_nxt == sps_pkg::ACK_DRIVE;
      ack_n_r <= ack_st_nxt != sps_pkg::ACK_DRIVE;
    end
  end

  assign transfer_ack_n_o = ack_n_r;
  assign transfer_ack_n_oe = ack_oe_r;
  assign host_addr = haddr_r;
  assign host_addr_valid = hval_r;

  a_ack_drive_low: assert property (@(posedge clk_sys) disable iff (srst)
    transfer_ack_n_oe == !transfer_ack_n_o) // [RQ1]
    else $error("acknowledge enabled without driving low");
  a_ack_timing: assert property (@(posedge clk_sys) disable iff (srst)
    ack_st_r == sps_pkg::ACK_IDLE && access ##1 access[*2] |=> transfer_ack_n_oe) // [RQ1]
    else $error("acknowledge late after access");
  a_ack_release: assert property (@(posedge clk_sys) disable iff (srst)
    transfer_ack_n_oe && !access |=> !transfer_ack_n_oe) // [RQ1]
    else $error("acknowledge held after access ended");
  a_addr_low: assert property (@(posedge clk_sys) disable iff (srst)
    ack_st_r == sps_pkg::ACK_IDLE && access && func_r[sps_pkg::FUNC_LOW_ADDR]
    |=> host_addr[5:0] == $past({mid_s, low_s})) // [RQ9] [RQ11]
    else $error("low address bits not taken from shared pins");

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [7:0] rdata_r, rdata_nxt;

  always_comb
  begin
    rdata_nxt = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        sps_pkg::REG_MODE: rdata_nxt = mode_r;
        sps_pkg::REG_STAT: rdata_nxt = {5'h00, fmt_gci_r, fmt_valid, ovr_r};
        sps_pkg::REG_ADDR: rdata_nxt = haddr_r;
        sps_pkg::REG_CHAN: rdata_nxt = chan_r;
        sps_pkg::REG_FUNC: rdata_nxt = {2'h0, func_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      rdata_r <= '0;
    else
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata = rdata_r;

endmodule : sps_pin_select
`default_nettype wire

// ==== rtl/sps_pkg.sv ====
// Constants and types shared by the shared-pin function select block
package sps_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_ADDR = 4'h2;
  localparam logic [3:0] REG_CHAN = 4'h3;
  localparam logic [3:0] REG_FUNC = 4'h4;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int MODE_RATE_LSB = 0;
  localparam int MODE_CLK8_BIT = 2;
  localparam int MODE_MUX_BIT = 3;
  localparam int MODE_8X4_BIT = 4;
  localparam int MODE_16X8_BIT = 5;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [1:0] RATE_2M = 2'h0;
  localparam logic [1:0] RATE_4M = 2'h1;
  localparam logic [1:0] RATE_8M = 2'h2;
  localparam logic [7:0] CHAN_BASE = 8'h20;

  // ----------------------------------------------------------------
  // Status and pin function fields
  // ----------------------------------------------------------------
  localparam int STAT_OVR_BIT = 0;
  localparam int STAT_FMTV_BIT = 1;
  localparam int STAT_GCI_BIT = 2;
  localparam int FUNC_IN6_ADDR = 0;
  localparam int FUNC_IN7_ADDR = 1;
  localparam int FUNC_LOW_ADDR = 2;
  localparam int FUNC_MID_ADDR = 3;
  localparam int FUNC_LOW_SER = 4;
  localparam int FUNC_MID_SER = 5;

  // ----------------------------------------------------------------
  // Stream, sync and timing
  // ----------------------------------------------------------------
  localparam int WORD_W = 14;
  localparam int SYNC_W = 20;
  localparam int LEN_W = 16;
  localparam logic [15:0] LEN_MAX = 16'hffff;
  localparam int CLK_NS = 20;
  localparam int ACK_DLY_NS = 40;
  localparam logic [1:0] ACK_DLY_CYC = 2'((ACK_DLY_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {ACK_IDLE, ACK_WAIT, ACK_DRIVE} sps_ack_t;

endpackage : sps_pkg

// ==== sim/sps_far_model.sv ====
// Far-side model: serial clock, frame pulse and the pulled-up acknowledge line
`timescale 1ns/1ps
`default_nettype none
module sps_far_model #(
  parameter int FRAME_CLKS = 64,
  parameter real HALF_NS = 122.0
) (
  // Frame format and serial clock speed choice from the bench
  input wire logic gci,
  input wire logic fast,
  // Acknowledge pin of the block
  input wire logic ack_n_o,
  input wire logic ack_n_oe,
  output logic ack_wire,
  // Serial timing
  output logic serial_clk,
  output logic frame_sync_in
);
  int cnt;

  // Open-drain line with a pull-up: high whenever nobody drives it
  assign ack_wire = (ack_n_oe === 1'b1) ? ack_n_o : 1'b1;

  // Shift clock near 4.096 MHz, or near 8.192 MHz when fast is set, runs freely, frames back to back
  initial
  begin
    serial_clk = 1'b0;
    cnt = 0;
    frame_sync_in = 1'b1;
    forever #((fast === 1'b1) ? HALF_NS / 2.0 : HALF_NS) serial_clk = ~serial_clk;
  end

  // One-clock frame pulse, low for one format and high for the other
  always @(negedge serial_clk)
  begin
    cnt <= (cnt == FRAME_CLKS - 1) ? 0 : cnt + 1;
    frame_sync_in <= gci ? (cnt == 0) : (cnt != 0);
  end
endmodule : sps_far_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the shared-pin function select block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys, srst, reg_wr, reg_rd, host_cs_n, host_ds, st_ready, gci;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, host_addr;
  logic ack_o, ack_oe, ack_wire, host_addr_valid, in6, in7, out6, out7;
  logic sclk, fsync, st_valid, fmt_gci, fast;
  logic [5:0] ser, pin_func;
  logic [2:0] low, mid;
  logic [13:0] st_word;
  int n_mismatch = 0;
  int cmp_count = 0;
  localparam logic [7:0] MODES [11] = '{8'h00, 8'h01, 8'h11, 8'h02, 8'h06, 8'h03,
    8'h08, 8'h0a, 8'h28, 8'h2a, 8'h20};

  sps_pin_select dut_u (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .host_cs_n(host_cs_n), .host_ds(host_ds), .transfer_ack_n_o(ack_o),
    .transfer_ack_n_oe(ack_oe), .host_addr(host_addr), .host_addr_valid(host_addr_valid),
    .serial_in_0_to_5(ser), .shared_in6_addr6_pin(in6), .shared_in7_addr7_pin(in7),
    .low_addr_or_serial_8_10(low), .mid_addr_or_serial_11_13(mid),
    .shared_out6_addr6_pin(out6), .shared_out7_addr7_pin(out7),
    .frame_sync_in(fsync), .serial_clk(sclk), .st_word(st_word), .st_valid(st_valid),
    .st_ready(st_ready), .pin_func(pin_func), .frame_fmt_gci(fmt_gci));

  sps_far_model far_u (.gci(gci), .fast(fast), .ack_n_o(ack_o), .ack_n_oe(ack_oe),
    .ack_wire(ack_wire), .serial_clk(sclk), .frame_sync_in(fsync));

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(nm, {8'h00, e}, {8'h00, reg_rdata});
  endtask : rdc

  function automatic logic [5:0] exp_func(input logic [7:0] m);
    logic [1:0] r;
    r = m[1:0];
    exp_func[0] = !m[3] && (r == 2'h2 || (r == 2'h1 && !m[4]));
    exp_func[1] = !m[3] && r == 2'h2;
    exp_func[2] = !m[3];
    exp_func[3] = !m[3];
    exp_func[4] = m[3] && m[5];
    exp_func[5] = m[3] && m[5];
  endfunction : exp_func

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    @(posedge clk_sys);
    #1;
    chk("pin_func", 16'h000c, {10'h0, pin_func});
    chk("ack_wire", 16'h0001, {15'h0, ack_wire});
    rdc("mode", sps_pkg::REG_MODE, 8'h00);
    rdc("chan", sps_pkg::REG_CHAN, 8'h20);
    @(posedge clk_sys);
    #1;
    chk("rdata_idle", 16'h0000, {8'h00, reg_rdata});
    wr(4'h9, 8'hff);
    rdc("unmapped", 4'hf, 8'h00);
    rdc("mode_kept", sps_pkg::REG_MODE, 8'h00);
  endtask : t_reset

  task automatic t_modes();
    logic [7:0] ch;
    foreach (MODES[i])
    begin
      ch = (MODES[i][1:0] == 2'h3) ? 8'h20 : (8'h20 << MODES[i][1:0]);
      wr(sps_pkg::REG_MODE, MODES[i]);
      rdc("mode", sps_pkg::REG_MODE, MODES[i]);
      rdc("func_reg", sps_pkg::REG_FUNC, {2'h0, exp_func(MODES[i])});
      chk("pin_func", {10'h0, exp_func(MODES[i])}, {10'h0, pin_func});
      rdc("chan", sps_pkg::REG_CHAN, ch);
    end
  endtask : t_modes

  task automatic t_host(input logic [7:0] m, input logic [7:0] ea, input logic ev);
    int k;
    wr(sps_pkg::REG_MODE, m);
    @(posedge clk_sys);
    host_cs_n <= 1'b0;
    host_ds <= 1'b1;
    for (k = 0; k < 20 && ack_wire !== 1'b0; k++)
      @(posedge clk_sys);
    #1;
    chk("ack_low", 16'h0000, {15'h0, ack_wire});
    chk("host_addr", {8'h00, ea}, {8'h00, host_addr});
    chk("addr_valid", {15'h0, ev}, {15'h0, host_addr_valid});
    rdc("addr_reg", sps_pkg::REG_ADDR, ea);
    @(posedge clk_sys);
    host_cs_n <= 1'b1;
    host_ds <= 1'b0;
    for (k = 0; k < 10 && ack_wire !== 1'b1; k++)
      @(posedge clk_sys);
    #1;
    chk("ack_release", 16'h0001, {15'h0, ack_wire});
    @(posedge clk_sys);
    host_cs_n <= 1'b0;
    host_ds <= 1'b1;
    @(posedge clk_sys);
    host_cs_n <= 1'b1;
    host_ds <= 1'b0;
    for (k = 0; k < 12; k++)
    begin
      @(posedge clk_sys);
      #1;
      if (ack_wire !== 1'b1)
        break;
    end
    chk("ack_abort", 16'h0001, {15'h0, ack_wire});
  endtask : t_host

  task automatic t_stream(input logic [7:0] m, input logic [13:0] ew, input logic ovr);
    int k;
    wr(sps_pkg::REG_MODE, m);
    st_ready <= 1'b1;
    repeat (60) @(posedge clk_sys);
    st_ready <= 1'b0;
    for (k = 0; k < 300 && st_valid !== 1'b1; k++)
      @(posedge clk_sys);
    #1;
    chk("st_word", {2'h0, ew}, {2'h0, st_word});
    if (ovr)
    begin
      repeat (400) @(posedge clk_sys);
      rdc("overrun", sps_pkg::REG_STAT, {5'h0, fmt_gci, 2'h3});
      st_ready <= 1'b1;
      wr(sps_pkg::REG_STAT, 8'h01);
      rdc("overrun_clr", sps_pkg::REG_STAT, {5'h0, fmt_gci, 2'h2});
    end
    st_ready <= 1'b1;
  endtask : t_stream

  task automatic t_fmt(input logic g);
    int k;
    gci <= g;
    for (k = 0; k < 4000 && fmt_gci !== g; k++)
      @(posedge clk_sys);
    repeat (1600) @(posedge clk_sys);
    #1;
    chk("fmt_gci", {15'h0, g}, {15'h0, fmt_gci});
    rdc("fmt_stat", sps_pkg::REG_STAT, {5'h0, g, 2'h2});
  endtask : t_fmt

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    host_cs_n = 1'b1;
    host_ds = 1'b0;
    st_ready = 1'b1;
    gci = 1'b0;
    fast = 1'b0;
    ser = 6'h2d;
    in6 = 1'b1;
    in7 = 1'b0;
    out6 = 1'b0;
    out7 = 1'b1;
    low = 3'h6;
    mid = 3'h3;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_modes();
    t_host(8'h00, 8'h9e, 1'b1);
    t_host(8'h01, 8'hde, 1'b1);
    t_host(8'h02, 8'h5e, 1'b1);
    t_host(8'h08, 8'h00, 1'b0);
    t_stream(8'h00, 14'h006d, 1'b1);
    t_stream(8'h28, 14'h1e6d, 1'b0);
    t_stream(8'h02, 14'h002d, 1'b0);
    fast = 1'b1;
    t_stream(8'h04, 14'h006d, 1'b0);
    fast = 1'b0;
    t_fmt(1'b1);
    t_fmt(1'b0);
    report_and_stop();
  end

  initial
  begin
    #(60000 * 20);
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
